// [include/mcoam_consts.svh]
/*
  Constants for the media converter OAM pin control block: register offsets,
  field positions, reset values and OAM register depth.
  Assumes it is included by bare name from the design files.
*/
`ifndef MCOAM_CONSTS_SVH
`define MCOAM_CONSTS_SVH

// register offsets on the 8-bit register port
`define MCOAM_LOOP_SEL_OFS   8'h0b
`define MCOAM_FLOW_CTL_OFS   8'h12
`define MCOAM_LINK_CTL_OFS   8'h1c
`define MCOAM_OAM_BASE       8'h40
`define MCOAM_OAM_LAST       8'h5f

// port1_link_control fields
`define MCOAM_LC_AUTONEG     7
`define MCOAM_LC_SPEED       6
`define MCOAM_LC_DUPLEX      5
// port1_flow_control field
`define MCOAM_FC_PAUSE       4
// loop select field in register 0x0b
`define MCOAM_LS_HI          3
`define MCOAM_LS_LO          2

// management register 0 fields
`define MCOAM_MII_AUTONEG    12
`define MCOAM_MII_SPEED      13
`define MCOAM_MII_DUPLEX     8

// reset value before the straps are loaded, and OAM register depth
`define MCOAM_REG_RESET      8'h00
`define MCOAM_OAM_DEPTH      32

`endif

// [include/mcoam_pkg.sv]
/*
  Types for the media converter OAM pin control block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package mcoam_pkg;

  // operating mode from the two mode straps (high, low)
  typedef enum logic [1:0] {
    MCOAM_SWITCH   = 2'h0,
    MCOAM_CENTER   = 2'h1,
    MCOAM_TERM_NMII = 2'h2,
    MCOAM_TERM_MII = 2'h3
  } mcoam_mode_e;

  // loop-back turnaround point
  typedef enum logic [1:0] {
    MCOAM_LP_P1_PHY = 2'h0,
    MCOAM_LP_P2_MAC = 2'h1,
    MCOAM_LP_P2_UTP = 2'h2
  } mcoam_loop_e;

  // indication frame launcher states, one-hot
  typedef enum logic [1:0] {
    MCOAM_IDLE = 2'h1,
    MCOAM_SEND = 2'h2
  } mcoam_state_e;

endpackage

// [core/mcoam_oam_regs.sv]
/*
  Storage for the 32 dedicated OAM converter registers.
  Assumes word-wide writes and a registered read port; index is the
  offset minus the window base.
*/
`include "mcoam_consts.svh"
module mcoam_oam_regs (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rstn,
  // access port
  input  wire logic       we,
  input  wire logic [4:0] idx,
  input  wire logic [7:0] wdata,
  output logic      [7:0] rdata
);

  logic [7:0] mem_reg [`MCOAM_OAM_DEPTH];

  // write port
  always_ff @(posedge clk) begin
    if (we) begin
      mem_reg[idx] <= wdata;
    end
  end

  // registered read port
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rdata <= `MCOAM_REG_RESET;
    end else begin
      rdata <= mem_reg[idx];
    end
  end

endmodule

// [core/mcoam_pin_ctrl.sv]
/*
  Pin-level control of the OAM sub-layer of a fiber media converter:
  straps, terminal status inputs, indication frame requests, loop-back
  steering, fault LED and port 1 fiber configuration registers.
  Assumes straps and status pins are synchronous to clk and that an
  external OAM encoder takes indication requests over a valid/ready pair.
*/
//
// Behaviour
// - falling power-down input requests indication frame with S0 set
// - power-down input high means normal, low means power down
// - any diagnostic input change requests indication with S3 equal new level
// - fault LED low on far-end fault, partner port down, or loop-back
// - error-drop strap high: drop OAM and errored frames while looping
// - error-drop strap low: drop only OAM frames while looping
// - loop point strap high loops at port 1 PHY, low at port 2 MAC
// - loop point also selectable by two-bit field of register 0x0b
// - terminal mode enables missing-link feature from its strap
// - thirty-two OAM registers at 0x40 to 0x5f
// - fiber full duplex may enable pause frame transmission
// - management register 0 bits 12, 13, 8 and straps share port settings
// - register 0x1c bits 7, 6, 5 hold autoneg, speed, duplex
// - forced pause from strap or register 0x12 bit 4 only
// - mode straps choose switch, center, terminal without MII, terminal with MII
// - S0 one is power down, S3 one is converter broken
`include "mcoam_consts.svh"
module mcoam_pin_ctrl (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rstn,
  // straps
  input  wire logic       mode_select_high,
  input  wire logic       mode_select_low,
  input  wire logic       loop_error_drop_strap,
  input  wire logic       loop_point_strap,
  input  wire logic       missing_link_strap,
  input  wire logic       port1_media_mux_strap,
  input  wire logic       autoneg_strap,
  input  wire logic       speed_strap,
  input  wire logic       duplex_strap,
  input  wire logic       forced_pause_strap,
  // terminal status pins
  input  wire logic       power_down_detect_n,
  input  wire logic       diag_fail_input,
  input  wire logic       fiber_signal_detect,
  // fault sources
  input  wire logic       far_end_fault,
  input  wire logic       partner_port_down,
  input  wire logic       loop_active,
  // register port
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_we,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  // management register 0 port
  input  wire logic        mii_we,
  input  wire logic [15:0] mii_wdata,
  output logic      [15:0] mii_rdata,
  // indication frame request to the oam encoder
  output logic            ind_valid,
  input  wire logic       ind_ready,
  output logic            ind_s0,
  output logic            ind_s3,
  // loop-back frame filter
  input  wire logic       lb_frame_valid,
  input  wire logic       lb_is_oam,
  input  wire logic       lb_crc_err,
  input  wire logic       lb_undersize,
  input  wire logic       lb_oversize,
  output logic            lb_verdict_valid,
  output logic            lb_drop,
  // configuration outputs
  output logic [1:0]      oper_mode,
  output logic [1:0]      loop_point,
  output logic            missing_link_en,
  output logic            fiber_mode,
  output logic            p1_autoneg_en,
  output logic            p1_speed_100,
  output logic            p1_full_duplex,
  output logic            p1_pause_tx_en,
  output logic            fiber_fault_led_n
);

  logic                   strap_done_reg;
  logic [1:0]             mode_reg;
  logic                   drop_strap_reg;
  logic                   lpt_strap_reg;
  logic                   ml_strap_reg;
  logic                   mux_strap_reg;
  logic [7:0]             loop_sel_reg;
  logic [7:0]             flow_ctl_reg;
  logic [7:0]             link_ctl_reg;
  logic [2:0]             pdd_sync_reg;
  logic [2:0]             diag_sync_reg;
  logic                   pend_pwr_reg;
  logic                   pend_diag_reg;
  mcoam_pkg::mcoam_state_e state_reg;
  logic                   pwr_fall;
  logic                   diag_edge;
  logic                   launch;
  logic                   oam_win;
  logic                   terminal;
  logic [7:0]             oam_rdata;
  logic                   oam_rd_sel_reg;
  logic [7:0]             cfg_rdata_reg;

  // straps are caught on the first edge after reset release
  always_ff @(posedge clk) begin
    if (!rstn) begin
      strap_done_reg <= 1'b0;
      mode_reg       <= 2'h0;
      drop_strap_reg <= 1'b0;
      lpt_strap_reg  <= 1'b0;
      ml_strap_reg   <= 1'b0;
      mux_strap_reg  <= 1'b0;
    end else if (!strap_done_reg) begin
      strap_done_reg <= 1'b1;
      mode_reg       <= {mode_select_high, mode_select_low};
      drop_strap_reg <= loop_error_drop_strap;
      lpt_strap_reg  <= loop_point_strap;
      ml_strap_reg   <= missing_link_strap;
      mux_strap_reg  <= port1_media_mux_strap;
    end
  end

  assign oam_win  = (reg_addr >= `MCOAM_OAM_BASE) && (reg_addr <= `MCOAM_OAM_LAST);
  assign terminal = mode_reg[1];

  // configuration registers; straps load, then software and mii writes share bits
  always_ff @(posedge clk) begin
    if (!rstn) begin
      loop_sel_reg <= `MCOAM_REG_RESET;
      flow_ctl_reg <= `MCOAM_REG_RESET;
      link_ctl_reg <= `MCOAM_REG_RESET;
    end else if (!strap_done_reg) begin
      link_ctl_reg[`MCOAM_LC_AUTONEG] <= autoneg_strap;
      link_ctl_reg[`MCOAM_LC_SPEED]   <= speed_strap;
      link_ctl_reg[`MCOAM_LC_DUPLEX]  <= duplex_strap;
      flow_ctl_reg[`MCOAM_FC_PAUSE]   <= forced_pause_strap;
    end else if (mii_we) begin
      link_ctl_reg[`MCOAM_LC_AUTONEG] <= mii_wdata[`MCOAM_MII_AUTONEG];
      link_ctl_reg[`MCOAM_LC_SPEED]   <= mii_wdata[`MCOAM_MII_SPEED];
      link_ctl_reg[`MCOAM_LC_DUPLEX]  <= mii_wdata[`MCOAM_MII_DUPLEX];
    end else if (reg_we) begin
      case (reg_addr)
        `MCOAM_LOOP_SEL_OFS: loop_sel_reg <= reg_wdata;
        `MCOAM_FLOW_CTL_OFS: flow_ctl_reg <= reg_wdata;
        `MCOAM_LINK_CTL_OFS: link_ctl_reg <= reg_wdata;
        default: ;
      endcase
    end
  end

  // dedicated oam register storage
  mcoam_oam_regs u_oam_regs (
    .clk   (clk),
    .rstn  (rstn),
    .we    (reg_we && oam_win),
    .idx   (reg_addr[4:0]),
    .wdata (reg_wdata),
    .rdata (oam_rdata)
  );

  // read mux; unmapped offsets read zero, the window reads from storage
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cfg_rdata_reg  <= `MCOAM_REG_RESET;
      oam_rd_sel_reg <= 1'b0;
    end else begin
      oam_rd_sel_reg <= oam_win;
      case (reg_addr)
        `MCOAM_LOOP_SEL_OFS: cfg_rdata_reg <= loop_sel_reg;
        `MCOAM_FLOW_CTL_OFS: cfg_rdata_reg <= flow_ctl_reg;
        `MCOAM_LINK_CTL_OFS: cfg_rdata_reg <= link_ctl_reg;
        default:             cfg_rdata_reg <= `MCOAM_REG_RESET;
      endcase
    end
  end

  assign reg_rdata = oam_rd_sel_reg ? oam_rdata : cfg_rdata_reg;

  // management register 0 view of the shared settings
  always_comb begin
    mii_rdata                    = 16'h0000;
    mii_rdata[`MCOAM_MII_AUTONEG] = link_ctl_reg[`MCOAM_LC_AUTONEG];
    mii_rdata[`MCOAM_MII_SPEED]   = link_ctl_reg[`MCOAM_LC_SPEED];
    mii_rdata[`MCOAM_MII_DUPLEX]  = link_ctl_reg[`MCOAM_LC_DUPLEX];
  end

  // two-stage synchronisers plus a history stage for edge detection
  always_ff @(posedge clk) begin
    if (!rstn) begin
      pdd_sync_reg  <= 3'h7;
      diag_sync_reg <= 3'h0;
    end else begin
      pdd_sync_reg  <= {pdd_sync_reg[1:0], power_down_detect_n};
      diag_sync_reg <= {diag_sync_reg[1:0], diag_fail_input};
    end
  end

  assign pwr_fall  = pdd_sync_reg[2] && !pdd_sync_reg[1];
  assign diag_edge = diag_sync_reg[2] != diag_sync_reg[1];
  assign launch    = (state_reg == mcoam_pkg::MCOAM_IDLE) &&
                     (pend_pwr_reg || pend_diag_reg);

  // one pending event per source; a new event wins over the clear
  always_ff @(posedge clk) begin
    if (!rstn) begin
      pend_pwr_reg  <= 1'b0;
      pend_diag_reg <= 1'b0;
    end else begin
      pend_pwr_reg  <= pwr_fall  || (pend_pwr_reg  && !launch);
      pend_diag_reg <= diag_edge || (pend_diag_reg && !launch);
    end
  end

  // indication launcher; status bits frozen while a request is offered
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_reg <= mcoam_pkg::MCOAM_IDLE;
      ind_s0    <= 1'b0;
      ind_s3    <= 1'b0;
    end else begin
      case (state_reg)
        mcoam_pkg::MCOAM_IDLE: begin
          if (launch) begin
            state_reg <= mcoam_pkg::MCOAM_SEND;
            ind_s0    <= !pdd_sync_reg[1];
            ind_s3    <= diag_sync_reg[1];
          end
        end
        mcoam_pkg::MCOAM_SEND: begin
          if (ind_ready) begin
            state_reg <= mcoam_pkg::MCOAM_IDLE;
          end
        end
        default: state_reg <= mcoam_pkg::MCOAM_IDLE;
      endcase
    end
  end

  assign ind_valid = (state_reg == mcoam_pkg::MCOAM_SEND);

  // loop-back filter verdict, one cycle after the frame summary
  always_ff @(posedge clk) begin
    if (!rstn) begin
      lb_verdict_valid <= 1'b0;
      lb_drop          <= 1'b0;
    end else begin
      lb_verdict_valid <= lb_frame_valid && loop_active;
      if (drop_strap_reg) begin
        lb_drop <= lb_is_oam || lb_crc_err || lb_undersize || lb_oversize;
      end else begin
        lb_drop <= lb_is_oam;
      end
    end
  end

  // turnaround point: field 00 follows the strap, others override it
  always_ff @(posedge clk) begin
    if (!rstn) begin
      loop_point <= mcoam_pkg::MCOAM_LP_P2_MAC;
    end else begin
      case (loop_sel_reg[`MCOAM_LS_HI:`MCOAM_LS_LO])
        2'h1:    loop_point <= mcoam_pkg::MCOAM_LP_P1_PHY;
        2'h2:    loop_point <= mcoam_pkg::MCOAM_LP_P2_MAC;
        2'h3:    loop_point <= mcoam_pkg::MCOAM_LP_P2_UTP;
        default: loop_point <= lpt_strap_reg ? mcoam_pkg::MCOAM_LP_P1_PHY
                                             : mcoam_pkg::MCOAM_LP_P2_MAC;
      endcase
    end
  end

  // mode, fiber configuration and fault indicator
  always_ff @(posedge clk) begin
    if (!rstn) begin
      oper_mode         <= 2'h0;
      missing_link_en   <= 1'b0;
      fiber_mode        <= 1'b0;
      p1_autoneg_en     <= 1'b0;
      p1_speed_100      <= 1'b0;
      p1_full_duplex    <= 1'b0;
      p1_pause_tx_en    <= 1'b0;
      fiber_fault_led_n <= 1'b1;
    end else begin
      oper_mode       <= mode_reg;
      missing_link_en <= terminal && ml_strap_reg;
      fiber_mode      <= fiber_signal_detect && !mux_strap_reg;
      p1_autoneg_en   <= link_ctl_reg[`MCOAM_LC_AUTONEG];
      p1_speed_100    <= link_ctl_reg[`MCOAM_LC_SPEED];
      p1_full_duplex  <= link_ctl_reg[`MCOAM_LC_DUPLEX];
      p1_pause_tx_en  <= link_ctl_reg[`MCOAM_LC_DUPLEX] &&
                         flow_ctl_reg[`MCOAM_FC_PAUSE];
      fiber_fault_led_n <= !(far_end_fault || partner_port_down ||
                             loop_active);
    end
  end

endmodule

// [bench/mcoam_pin_ctrl_properties.sv]
/*
  Concurrent checks on the ports of the OAM pin control block.
  Assumes straps only change while rstn is low.
*/
module mcoam_pin_ctrl_props (
  // clock and reset
  input wire logic       clk,
  input wire logic       rstn,
  // straps and status pins
  input wire logic       mode_select_high,
  input wire logic       mode_select_low,
  input wire logic       loop_error_drop_strap,
  input wire logic       missing_link_strap,
  input wire logic       power_down_detect_n,
  input wire logic       diag_fail_input,
  input wire logic       far_end_fault,
  input wire logic       partner_port_down,
  input wire logic       loop_active,
  // indication handshake
  input wire logic       ind_valid,
  input wire logic       ind_ready,
  input wire logic       ind_s0,
  input wire logic       ind_s3,
  // loop-back filter
  input wire logic       lb_frame_valid,
  input wire logic       lb_is_oam,
  input wire logic       lb_crc_err,
  input wire logic       lb_undersize,
  input wire logic       lb_oversize,
  input wire logic       lb_verdict_valid,
  input wire logic       lb_drop,
  // configuration
  input wire logic [1:0] oper_mode,
  input wire logic       missing_link_en,
  input wire logic       fiber_fault_led_n
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // fault indicator, verdicts, handshake, events and straps
  a_led_fault: assert property (
    $past(rstn) |-> fiber_fault_led_n == !$past(far_end_fault | partner_port_down | loop_active))
    else $error("fault led does not follow fault sources");
  a_drop_choice: assert property (
    lb_frame_valid && loop_active |=> lb_verdict_valid && lb_drop == ($past(lb_is_oam)
      | (loop_error_drop_strap & $past(lb_crc_err | lb_undersize | lb_oversize))))
    else $error("loop-back verdict wrong");
  a_no_verdict: assert property (
    !(lb_frame_valid && loop_active) |=> !lb_verdict_valid)
    else $error("verdict without looped frame");
  a_ind_hold: assert property (
    ind_valid && !ind_ready |=> ind_valid && $stable(ind_s0) && $stable(ind_s3))
    else $error("indication request not held");
  a_ind_release: assert property (
    ind_valid && ind_ready |=> !ind_valid)
    else $error("indication request not released");
  a_power_event: assert property (
    $fell(power_down_detect_n) |-> ##[3:20] ind_valid && ind_s0)
    else $error("no power-down indication");
  a_diag_event: assert property (
    $changed(diag_fail_input) |-> ##[3:20] ind_valid && ind_s3 == diag_fail_input)
    else $error("no diagnostic indication");
  a_mode_straps: assert property (
    $past(rstn) && $past(rstn, 2) |-> oper_mode == {mode_select_high, mode_select_low}
      && missing_link_en == (mode_select_high & missing_link_strap))
    else $error("mode straps not applied");

  // main scenarios
  c_frame: cover property (ind_valid && ind_ready);
  c_drop: cover property (lb_verdict_valid && lb_drop);
  c_pass: cover property (lb_verdict_valid && !lb_drop);
endmodule

bind mcoam_pin_ctrl mcoam_pin_ctrl_props u_props (.*);

// [bench/mcoam_encoder_model.sv]
/*
  Model of the OAM encoder that takes indication requests.
  Assumes valid/ready with ready raised only while valid is high.
*/
module mcoam_encoder_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rstn,
  // request side
  input  wire logic       ind_valid,
  input  wire logic       ind_s0,
  input  wire logic       ind_s3,
  input  wire logic       slow,
  output logic            ind_ready,
  // observed frames
  output logic      [7:0] frames,
  output logic            got_s0,
  output logic            got_s3
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] wait_cnt;

  // raise ready after 1 or 4 cycles of valid, keep the status bits of each frame
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ind_ready <= 1'b0;
      frames    <= 8'h00;
      wait_cnt  <= 2'h0;
    end else if (ind_valid && ind_ready) begin
      frames    <= frames + 8'h01;
      got_s0    <= ind_s0;
      got_s3    <= ind_s3;
      ind_ready <= 1'b0;
      wait_cnt  <= 2'h0;
    end else if (ind_valid) begin
      ind_ready <= !slow || wait_cnt == 2'h3;
      wait_cnt  <= wait_cnt + 2'h1;
    end
  end
endmodule

// [bench/tb.sv]
/*
  Self-checking bench of the OAM pin control block with an encoder model.
  Assumes the design and checker files are compiled before it.
*/
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, rstn, mode_select_high, mode_select_low, loop_error_drop_strap;
  logic        loop_point_strap, missing_link_strap, port1_media_mux_strap, autoneg_strap;
  logic        speed_strap, duplex_strap, forced_pause_strap, power_down_detect_n;
  logic        diag_fail_input, fiber_signal_detect, far_end_fault, partner_port_down;
  logic        loop_active, reg_we, mii_we, ind_valid, ind_ready, ind_s0, ind_s3, slow;
  logic        lb_frame_valid, lb_is_oam, lb_crc_err, lb_undersize, lb_oversize, lb_drop;
  logic        lb_verdict_valid, missing_link_en, fiber_mode, p1_autoneg_en, p1_speed_100;
  logic        p1_full_duplex, p1_pause_tx_en, fiber_fault_led_n, got_s0, got_s3;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, frames, rd;
  logic [15:0] mii_wdata, mii_rdata;
  logic [1:0]  oper_mode, loop_point;
  int          miscompares, checks;

  mcoam_pin_ctrl dut (.*);
  mcoam_encoder_model model (.*);

  // free-running clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic complete_run;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic do_reset(input logic [1:0] mode, input logic drop, input logic lpt);
    rstn = 1'b0;
    {mode_select_high, mode_select_low} = mode;
    loop_error_drop_strap = drop;
    loop_point_strap = lpt;
    repeat (3) @(negedge clk);
    rstn = 1'b1;
    repeat (3) @(negedge clk);
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_we = 1'b1;
    @(negedge clk);
    reg_we = 1'b0;
    @(negedge clk);
  endtask

  task automatic reg_read(input logic [7:0] a);
    reg_addr = a;
    @(negedge clk);
    rd = reg_rdata;
  endtask

  task automatic wait_frame(input logic s0, input logic s3);
    logic [7:0] start;
    start = frames;
    for (int i = 0; i < 40 && frames === start; i++) @(negedge clk);
    if (frames === start) begin
      miscompares++;
      complete_run();
    end else begin
      check({14'h0, got_s0, got_s3}, {14'h0, s0, s3});
    end
  endtask

  task automatic test_straps;
    check({14'h0, oper_mode}, 16'h3);
    check({15'h0, missing_link_en}, 16'h1);
    check({14'h0, loop_point}, 16'h0);
    check({15'h0, fiber_mode}, 16'h1);
    check(mii_rdata, 16'h2100);
    check({13'h0, p1_autoneg_en, p1_speed_100, p1_full_duplex}, 16'h3);
    check({15'h0, p1_pause_tx_en}, 16'h1);
    reg_read(8'h1c);
    check({8'h0, rd}, 16'h0060);
    reg_read(8'h12);
    check({8'h0, rd}, 16'h0010);
  endtask

  task automatic test_regs;
    logic [1:0] lp [4] = '{2'h0, 2'h0, 2'h1, 2'h2};
    for (int i = 3; i >= 0; i--) begin
      reg_write(8'h0b, 8'(i << 2));
      check({14'h0, loop_point}, {14'h0, lp[i]});
    end
    reg_write(8'h1c, 8'he0);
    check({13'h0, p1_autoneg_en, p1_speed_100, p1_full_duplex}, 16'h7);
    check(mii_rdata, 16'h3100);
    mii_wdata = 16'h0100;
    mii_we = 1'b1;
    @(negedge clk);
    mii_we = 1'b0;
    @(negedge clk);
    reg_read(8'h1c);
    check({8'h0, rd}, 16'h0020);
    check({13'h0, p1_autoneg_en, p1_speed_100, p1_full_duplex}, 16'h1);
    reg_write(8'h12, 8'h00);
    check({15'h0, p1_pause_tx_en}, 16'h0);
    reg_write(8'h12, 8'h10);
    check({15'h0, p1_pause_tx_en}, 16'h1);
    reg_write(8'h40, 8'ha5);
    reg_write(8'h5f, 8'h3c);
    reg_read(8'h40);
    check({8'h0, rd}, 16'h00a5);
    reg_read(8'h5f);
    check({8'h0, rd}, 16'h003c);
    reg_write(8'h30, 8'hff);
    reg_read(8'h30);
    check({8'h0, rd}, 16'h0000);
  endtask

  task automatic test_led;
    for (int i = 0; i < 4; i++) begin
      {far_end_fault, partner_port_down, loop_active} = (i == 0) ? 3'h0 : 3'(1 << (i - 1));
      repeat (2) @(negedge clk);
      check({15'h0, fiber_fault_led_n}, (i == 0) ? 16'h1 : 16'h0);
    end
    {far_end_fault, partner_port_down, loop_active} = 3'h0;
    fiber_signal_detect = 1'b0;
    repeat (2) @(negedge clk);
    check({15'h0, fiber_mode}, 16'h0);
    fiber_signal_detect = 1'b1;
  endtask

  task automatic test_loop(input logic drop);
    loop_active = 1'b1;
    for (int k = 0; k < 16; k++) begin
      {lb_is_oam, lb_crc_err, lb_undersize, lb_oversize} = 4'(k);
      lb_frame_valid = 1'b1;
      @(negedge clk);
      lb_frame_valid = 1'b0;
      check({14'h0, lb_verdict_valid, lb_drop}, {14'h0, 1'b1, lb_is_oam
        | (drop & (lb_crc_err | lb_undersize | lb_oversize))});
      @(negedge clk);
    end
    loop_active = 1'b0;
    lb_frame_valid = 1'b1;
    @(negedge clk);
    lb_frame_valid = 1'b0;
    check({15'h0, lb_verdict_valid}, 16'h0);
    @(negedge clk);
  endtask

  task automatic test_indication;
    logic [7:0] n;
    slow = 1'b1;
    power_down_detect_n = 1'b0;
    repeat (5) @(negedge clk);
    diag_fail_input = 1'b1;
    wait_frame(1'b1, 1'b0);
    wait_frame(1'b1, 1'b1);
    slow = 1'b0;
    n = frames;
    power_down_detect_n = 1'b1;
    repeat (12) @(negedge clk);
    check({8'h0, frames}, {8'h0, n});
    diag_fail_input = 1'b0;
    wait_frame(1'b0, 1'b0);
    power_down_detect_n = 1'b0;
    diag_fail_input = 1'b1;
    wait_frame(1'b1, 1'b1);
    power_down_detect_n = 1'b1;
    diag_fail_input = 1'b0;
    wait_frame(1'b0, 1'b0);
  endtask

  // main sequence
  initial begin
    {reg_we, mii_we, reg_addr, reg_wdata, mii_wdata} = '0;
    {far_end_fault, partner_port_down, loop_active, lb_frame_valid, slow} = '0;
    {lb_is_oam, lb_crc_err, lb_undersize, lb_oversize, diag_fail_input} = '0;
    power_down_detect_n = 1'b1;
    fiber_signal_detect = 1'b1;
    port1_media_mux_strap = 1'b0;
    autoneg_strap = 1'b0;
    {speed_strap, duplex_strap, forced_pause_strap, missing_link_strap} = 4'hf;
    do_reset(2'h3, 1'b1, 1'b1);
    test_straps();
    test_regs();
    test_led();
    test_loop(1'b1);
    test_indication();
    do_reset(2'h2, 1'b0, 1'b0);
    check({14'h0, loop_point}, 16'h1);
    check({15'h0, missing_link_en}, 16'h1);
    test_loop(1'b0);
    for (int m = 0; m < 2; m++) begin
      do_reset(2'(m), 1'b0, 1'b0);
      check({13'h0, oper_mode, missing_link_en}, 16'(m << 1));
    end
    complete_run();
  end
endmodule
